// [pkg/brk_pkg.sv]
// Constants and carrier types for the instruction-fetch break sequencer
// ==============================================================
// Overview of operation
// [R1] A taken software trap fetches the trap, two over-fetched successors, then the destination, and executes only trap and destination.
// [R2] A break match on either over-fetched successor raises the break at that instruction, and neither successor executes.
// [R3] A break match reaches the interrupt controller and starts exception handling no sooner than two clocks later.
// [R4] An interrupt raised before the break request arrives is taken first, and the break only after its handling completes.
// [R5] Hardware cannot prevent that reordering, so software must track a deferred break itself, for example with a flag.
// [R6] A taken branch_if_true or branch_if_false follows the same fetch and execute sequence as a taken trap.
// [R7] The break has priority 15 and is accepted only while the mask level is 14 or lower, else held pending.
package brk_pkg;
	// ==============================================================
	// Timing and levels
	localparam int          BRK_DELAY    = 2;
	localparam logic [3:0]  BRK_LEVEL    = 4'hF;
	localparam int          OVERFETCHES  = 2;

	// ==============================================================
	// Carriers
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic        is_trap;
		logic        is_cond_br;
		logic        taken;
		logic        brk_match;
	} fetch_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} exec_t;

	typedef enum logic [1:0] {
		SEQ_RUN,
		SEQ_OVER1,
		SEQ_OVER2,
		SEQ_DEST
	} seq_t;
endpackage

// [rtl/user_break_unit.sv]
// Break sequencer on the instruction fetch path with break request delivery
`timescale 1ns/1ns
module user_break_unit #(
	parameter int DELAY = brk_pkg::BRK_DELAY
) (
	input  wire logic           ref_clk,
	input  wire logic           nrst,
	input  brk_pkg::fetch_t     fetch,
	input  wire logic [3:0]     interrupt_mask_level,
	input  wire logic           other_irq_pend,
	input  wire logic           other_irq_done,
	output brk_pkg::exec_t      exec,
	output logic                brk_req,
	output logic                brk_take,
	output logic [31:0]         brk_pc
);
	// ==============================================================
	// Fetch sequence after a taken branch
	brk_pkg::seq_t seq_reg;
	brk_pkg::seq_t seq_next;
	logic          br_taken;
	logic          over_fetch;
	logic          do_exec;
	logic          new_brk;

	assign br_taken   = fetch.valid && fetch.taken && (fetch.is_trap || fetch.is_cond_br); // [R1] [R6]
	assign over_fetch = fetch.valid && (seq_reg == brk_pkg::SEQ_OVER1 ||
	                                    seq_reg == brk_pkg::SEQ_OVER2);
	assign do_exec    = fetch.valid && !over_fetch; // [R1] [R6]
	assign new_brk    = fetch.valid && fetch.brk_match; // [R2]

	always_comb begin
		seq_next = seq_reg;
		case (seq_reg)
			brk_pkg::SEQ_RUN: begin
				if (br_taken) seq_next = brk_pkg::SEQ_OVER1; // [R1] [R6]
			end
			brk_pkg::SEQ_OVER1: begin
				if (fetch.valid) seq_next = brk_pkg::SEQ_OVER2;
			end
			brk_pkg::SEQ_OVER2: begin
				if (fetch.valid) seq_next = brk_pkg::SEQ_DEST;
			end
			brk_pkg::SEQ_DEST: begin
				if (fetch.valid) seq_next = br_taken ? brk_pkg::SEQ_OVER1 : brk_pkg::SEQ_RUN;
			end
			default: begin
				seq_next = brk_pkg::SEQ_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) seq_reg <= brk_pkg::SEQ_RUN;
		else       seq_reg <= seq_next;
	end

	// Executed stream; over-fetched words never appear here
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) exec <= '0;
		else       exec <= '{valid: do_exec, addr: fetch.addr};
	end

	// ==============================================================
	// Over-fetch counter; only the checks read it
	localparam logic [1:0] OVER_MAX = 2'(brk_pkg::OVERFETCHES);
	logic [1:0]    over_cnt_reg;
	logic [1:0]    over_cnt_next;
	logic          br_restart;

	assign br_restart    = br_taken && (seq_reg == brk_pkg::SEQ_RUN ||
	                                    seq_reg == brk_pkg::SEQ_DEST);
	assign over_cnt_next = br_restart ? 2'h0 :
	                       over_fetch ? over_cnt_reg + 2'h1 : over_cnt_reg;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) over_cnt_reg <= 2'h0;
		else       over_cnt_reg <= over_cnt_next;
	end

	// ==============================================================
	// Break request pipeline toward the interrupt controller
	// A match on an over-fetch still raises the break at that address
	logic [DELAY-1:0] pipe_reg;
	logic [31:0]      pc_pipe_reg [DELAY];
	logic             pend_reg;
	logic             other_busy_reg;
	logic             accept;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) pipe_reg <= '0;
		else       pipe_reg <= {pipe_reg[DELAY-2:0], new_brk}; // [R3]
	end

	genvar gi;
	// Address rides alongside its match so the saved address is the matched one
	for (gi = 0; gi < DELAY; gi++) begin : g_pc
		if (gi == 0) begin : g_first
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) pc_pipe_reg[gi] <= 32'h0000_0000;
				else       pc_pipe_reg[gi] <= fetch.addr;
			end
		end else begin : g_rest
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) pc_pipe_reg[gi] <= 32'h0000_0000;
				else       pc_pipe_reg[gi] <= pc_pipe_reg[gi-1];
			end
		end
	end

	assign brk_req = pend_reg;

	// Earlier interrupt owns the CPU until its handling is done
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)                other_busy_reg <= 1'b0;
		else if (other_irq_pend && !pend_reg) other_busy_reg <= 1'b1; // [R4]
		else if (other_irq_done)  other_busy_reg <= 1'b0;
	end

	// Mask 15 holds the request pending; no hardware repairs reordering
	assign accept = pend_reg && !other_busy_reg && !other_irq_pend
	             && (interrupt_mask_level < brk_pkg::BRK_LEVEL); // [R4] [R7] [R5]

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pend_reg <= 1'b0;
			brk_pc   <= 32'h0000_0000;
		end else if (pipe_reg[DELAY-1] && !pend_reg) begin
			pend_reg <= 1'b1; // [R3]
			brk_pc   <= pc_pipe_reg[DELAY-1];
		end else if (accept) begin
			pend_reg <= 1'b0; // [R7]
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) brk_take <= 1'b0;
		else       brk_take <= accept;
	end

	// ==============================================================
	// Checks
	min_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
		new_brk && !brk_req && pipe_reg == '0 |=> !brk_req ##1 !brk_req)
		else $error("break delivered too early");

	over_noexec_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
		over_fetch |=> !exec.valid)
		else $error("over-fetched word executed");

	seq_two_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
		(seq_reg == brk_pkg::SEQ_RUN) && br_taken |=> seq_reg == brk_pkg::SEQ_OVER1)
		else $error("branch did not start over-fetch");

	mask_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
		brk_req && interrupt_mask_level == 4'hF |=> !brk_take)
		else $error("break taken at mask 15");

	order_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R4]
		other_busy_reg |=> !brk_take)
		else $error("break taken before earlier interrupt");

	cond_br_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R6]
		fetch.valid && fetch.is_cond_br && fetch.taken && seq_reg == brk_pkg::SEQ_RUN
		|=> exec.valid ##1 !exec.valid ##1 !exec.valid)
		else $error("conditional branch sequence broken");

	pend_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
		brk_req && !accept |=> brk_req)
		else $error("pending break lost");

	// ==============================================================
	// Further fetch sequence checks
	trap_seq_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
		fetch.valid && fetch.is_trap && fetch.taken && seq_reg == brk_pkg::SEQ_RUN
		|=> exec.valid ##1 !exec.valid ##1 !exec.valid)
		else $error("trap sequence broken");

	exec_addr_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1] [R6]
		do_exec |=> exec.valid && exec.addr == $past(fetch.addr))
		else $error("executed word lost or misaddressed");

	idle_noexec_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
		!fetch.valid |=> !exec.valid)
		else $error("execution without a fetch");

	over_count_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1] [R6]
		over_fetch |-> over_cnt_reg < OVER_MAX)
		else $error("too many over-fetched words");

	dest_count_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1] [R6]
		fetch.valid && seq_reg == brk_pkg::SEQ_DEST |-> over_cnt_reg == OVER_MAX)
		else $error("destination fetched too early");

	// ==============================================================
	// Further break delivery checks
	// The upper latency bound holds for the default pipe depth of two
	deliver_lat_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
		new_brk && !brk_req && pipe_reg == '0 |-> ##3 brk_req)
		else $error("break request late");

	pc_capture_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
		$rose(brk_req) |-> brk_pc == $past(fetch.addr, DELAY + 1))
		else $error("break address not the matched fetch");

	pc_stable_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
		brk_req && !accept |=> $stable(brk_pc))
		else $error("break address moved while pending");

	other_first_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R4]
		other_irq_pend |=> !brk_take)
		else $error("break taken over a pending interrupt");

	accept_open_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
		brk_req && !other_irq_pend && !other_busy_reg
		&& interrupt_mask_level < brk_pkg::BRK_LEVEL |=> brk_take)
		else $error("acceptable break not taken");

	take_once_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
		brk_take |=> !brk_take)
		else $error("break taken twice");

	take_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
		brk_take |-> !brk_req)
		else $error("request still pending after take");
endmodule

// [sim/irq_model.sv]
// Model of the other interrupt source facing the break unit
`timescale 1ns/1ns
module irq_model (
	input  wire logic       ref_clk,
	input  wire logic       nrst,
	input  wire logic       start,
	input  wire logic [3:0] hold,
	input  wire logic       brk_req,
	output logic            other_irq_pend,
	output logic            other_irq_done,
	output logic            brk_deferred
);
	logic [3:0] cnt_reg;
	logic       deferred_reg;
	assign brk_deferred = deferred_reg;
	// ==========
	// Pending until handled; the flag is how software learns a break was deferred
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			{other_irq_pend, other_irq_done, cnt_reg, deferred_reg} <= '0;
		end else begin
			other_irq_done <= other_irq_pend && cnt_reg == 4'h0;
			other_irq_pend <= start || (other_irq_pend && cnt_reg != 4'h0);
			cnt_reg <= start ? hold : cnt_reg - {3'h0, cnt_reg != 4'h0};
			deferred_reg <= deferred_reg || (brk_req && other_irq_pend);
		end
	end
endmodule

// [sim/user_break_unit_tb.sv]
// Self-checking bench for the break sequencer
`timescale 1ns/1ns
module user_break_unit_tb;
	logic ref_clk = 0, nrst = 0, start = 0, brk_req, brk_take, pend, done, deferred;
	logic [3:0] mask = 4'h0;
	logic [31:0] a, brk_pc, q_ex[$], q_bk[$];
	brk_pkg::fetch_t fetch = '0;
	brk_pkg::exec_t exec;
	int seed = 32'h46F390A7, fail_count = 0, cmp_count = 0, cyc = 0, t_match = 0;
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;
	user_break_unit dut (.ref_clk(ref_clk), .nrst(nrst), .fetch(fetch),
		.interrupt_mask_level(mask), .other_irq_pend(pend), .other_irq_done(done),
		.exec(exec), .brk_req(brk_req), .brk_take(brk_take), .brk_pc(brk_pc));
	irq_model partner (.ref_clk(ref_clk), .nrst(nrst), .start(start), .hold(4'h8),
		.brk_req(brk_req), .other_irq_pend(pend), .other_irq_done(done),
		.brk_deferred(deferred));
	// ==========
	task automatic chk(input logic ok, input string m);
		cmp_count++;
		if (ok !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task automatic finish_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic fe(input logic [31:0] ad, input logic tr, cb, tk, mt);
		@(posedge ref_clk);
		fetch <= '{1'b1, ad, tr, cb, tk, mt};
		if (mt) t_match <= cyc;
	endtask
	// Taken branch with an optional match on over-fetch mw
	task automatic br(input logic tr, input logic [1:0] mw);
		a = $random(seed) & 32'h00FF_FFFE;
		q_ex.push_back(a);
		fe(a, tr, !tr, 1'b1, 1'b0);
		fe(a + 2, 0, 0, 0, mw == 1);
		fe(a + 4, 0, 0, 0, mw == 2);
		q_ex.push_back(a + 32'h100);
		fe(a + 32'h100, 0, 0, 0, 0);
		if (mw != 0) q_bk.push_back(a + 2 * mw);
		@(posedge ref_clk) fetch <= '0;
	endtask
	task automatic wait_q;
		for (int n = 0; n < 60 && q_ex.size() + q_bk.size() != 0; n++) @(posedge ref_clk);
		if (q_ex.size() + q_bk.size() != 0) begin
			fail_count++;
			$display("[FAIL] %0t timeout", $time);
			finish_test;
		end
	endtask
	// ==========
	// Notes are taken off the queues as results appear
	always @(negedge ref_clk) if (nrst) begin
		if (exec.valid !== 1'b0) chk(q_ex.size() > 0 && exec.addr === q_ex.pop_front(), "exec");
		if (brk_take !== 1'b0) chk(q_bk.size() > 0 && brk_pc === q_bk.pop_front() && cyc - t_match >= 3 && pend === 1'b0, "break");
	end
	initial begin
		repeat (2) @(posedge ref_clk);
		chk(brk_req === 1'b0 && brk_take === 1'b0 && exec.valid === 1'b0, "reset");
		nrst <= 1;
		for (int i = 0; i < 4; i++) br(i[0], 2'd0);
		for (int i = 0; i < 4; i++) begin
			br(i[0], 2'd1 + i[1]);
			wait_q;
		end
		mask <= 4'hF;
		br(1, 2'd1);
		repeat (20) @(posedge ref_clk);
		chk(q_bk.size() == 1 && brk_req === 1'b1, "held");
		chk(deferred === 1'b0, "deferred too early");
		mask <= 4'hE;
		wait_q;
		start <= 1;
		@(posedge ref_clk) start <= 0;
		br(0, 2'd2);
		wait_q;
		chk(deferred === 1'b1, "deferral not flagged");
		finish_test;
	end
endmodule
